// >>> hdl/sseu_pkg.sv
// Package: constants, types and check-bit code for the SDRAM SEC-DED unit
package sseu_pkg;

  localparam int SSEU_DATA_W = 64;
  localparam int SSEU_CHK_W = 8;
  localparam int SSEU_WORD_W = 72;
  localparam int SSEU_BE_W = 8;
  localparam int SSEU_BURST_BEATS = 4;
  localparam int SSEU_BEAT_BYTES = 8;
  localparam int SSEU_LAST_POS = 71;
  localparam int SSEU_APB_AW = 12;

  // Register byte offsets
  localparam logic [11:0] SSEU_OFS_CTRL = 12'h000;
  localparam logic [11:0] SSEU_OFS_STATUS = 12'h004;
  localparam logic [11:0] SSEU_OFS_ELOG_ADDR = 12'h008;
  localparam logic [11:0] SSEU_OFS_ELOG_SYND = 12'h00C;
  localparam logic [11:0] SSEU_OFS_SBE_COUNT = 12'h010;

  // Control bits
  localparam int SSEU_CTRL_SBE_IRQ_EN = 0;
  localparam int SSEU_CTRL_MBE_IRQ_EN = 1;
  localparam int SSEU_CTRL_MCHK_EN = 2;
  localparam int SSEU_CTRL_SCRUB_WB_EN = 3;
  localparam int SSEU_CTRL_SCRUB_LOG_EN = 4;
  localparam int SSEU_CTRL_OVF_IRQ_EN = 5;
  localparam int SSEU_CTRL_W = 6;
  localparam logic [5:0] SSEU_CTRL_RESET = 6'h00;

  // Status bits
  localparam int SSEU_ST_SBE = 0;
  localparam int SSEU_ST_MBE = 1;
  localparam int SSEU_ST_OVF = 2;
  localparam int SSEU_ST_ELOG = 3;
  localparam int SSEU_ST_ELOG_MBE = 4;
  localparam int SSEU_ST_MCHK = 5;

  localparam int SSEU_SBE_CNT_W = 8;

  typedef enum logic [1:0] {OP_READ, OP_BURST_WR, OP_RMW, OP_SCRUB} sseu_op_t;
  typedef enum logic [2:0] {S_IDLE, S_RD_CMD, S_RD_WAIT, S_WR_CMD, S_WR_GAP, S_WR_LOAD} sseu_state_t;

  // Codeword position of data bit i: positions 3..71 skipping powers of two
  function automatic logic [6:0] sseu_pos(input int i);
    int n;
    logic [6:0] r;
    n = 0;
    r = 7'h00;
    for (int p = 3; p <= SSEU_LAST_POS; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (n == i)
          r = 7'(p);
        n++;
      end
    end
    return r;
  endfunction : sseu_pos

  // Seven Hamming bits plus an overall parity bit in the top position
  function automatic logic [7:0] sseu_ecc_gen(input logic [63:0] d);
    logic [7:0] c;
    logic [6:0] ps;
    c = 8'h00;
    for (int i = 0; i < SSEU_DATA_W; i++)
    begin
      ps = sseu_pos(i);
      for (int j = 0; j < 7; j++)
        if (ps[j])
          c[j] = c[j] ^ d[i];
    end
    c[7] = ^{d, c[6:0]};
    return c;
  endfunction : sseu_ecc_gen

endpackage : sseu_pkg

// >>> hdl/sseu_top.sv
// SDRAM SEC-DED unit: full-word SDRAM access, RMW, scrub, error log, APB registers
//
// Function
// - Correct single, detect double errors per word
// - ROM and Flash traffic gets no checking
// - Every SDRAM access moves the full 72-bit word
// - Any processor read fetches at least one word
// - Burst write encodes and writes four full words
// - Single write does read, merge, re-encode, write
// - Check reads, RMW reads and scrub reads
// - Never end a cycle with error acknowledge
// - Double error on CPU access asserts machine check
// - Single error read: normal end, corrected data
// - Single error RMW: correct, merge, store, interrupt
// - Scrub hidden; corrected write-back only if enabled
// - Double error read: normal end, raw data
// - Double error in RMW suppresses the write
// - Double error in scrub skips write-back
// - Burst writes report no error
// - Interrupt only from single, multiple, counter overflow
// - Three-bit errors may be misclassified
// - Log failing address and syndrome
// - Log frozen until cleared; double overrides single
// - Scrub errors logged only when enabled
`timescale 1ns/1ns
module sseu_top #(
  parameter int ADDR_W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sseu_pkg::SSEU_APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_req_valid,
  input wire logic cpu_req_sdram,
  input wire logic cpu_req_write,
  input wire logic cpu_req_burst,
  input wire logic [ADDR_W-1:0] cpu_req_addr,
  input wire logic [sseu_pkg::SSEU_BE_W-1:0] cpu_req_be,
  input wire logic [sseu_pkg::SSEU_DATA_W-1:0] cpu_wdata,
  output logic [sseu_pkg::SSEU_DATA_W-1:0] cpu_rdata,
  output logic cpu_beat,
  output logic cpu_done,
  input wire logic scrub_req,
  input wire logic [ADDR_W-1:0] scrub_addr,
  output logic scrub_done,
  output logic mem_cmd_valid,
  input wire logic mem_cmd_ready,
  output logic mem_cmd_write,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [sseu_pkg::SSEU_WORD_W-1:0] mem_wdata,
  input wire logic mem_rvalid,
  input wire logic [sseu_pkg::SSEU_WORD_W-1:0] mem_rdata,
  output logic err_irq,
  output logic machine_check_out_n
);
  import sseu_pkg::*;

  if (ADDR_W < 8 || ADDR_W > 32)
  begin : g_bad_addr_w
    $error("sseu_top: ADDR_W must lie between 8 and 32");
  end

  sseu_state_t st_reg, st_next;
  sseu_op_t op_reg, op_next;
  logic [1:0] beat_reg, beat_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [SSEU_BE_W-1:0] be_reg, be_next;
  logic mem_cmd_valid_reg, mem_cmd_valid_next;
  logic mem_cmd_write_reg, mem_cmd_write_next;
  logic [SSEU_WORD_W-1:0] mem_wdata_reg, mem_wdata_next;
  logic [SSEU_DATA_W-1:0] cpu_rdata_reg, cpu_rdata_next;
  logic cpu_beat_reg, cpu_beat_next;
  logic cpu_done_reg, cpu_done_next;
  logic scrub_done_reg, scrub_done_next;

  logic [SSEU_CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic sbe_ev_reg, sbe_ev_next;
  logic mbe_ev_reg, mbe_ev_next;
  logic ovf_reg, ovf_next;
  logic elog_reg, elog_next;
  logic elog_mbe_reg, elog_mbe_next;
  logic [ADDR_W-1:0] elog_addr_reg, elog_addr_next;
  logic [SSEU_CHK_W-1:0] elog_synd_reg, elog_synd_next;
  logic [SSEU_SBE_CNT_W-1:0] sbe_cnt_reg, sbe_cnt_next;
  logic mchk_n_reg, mchk_n_next;
  logic err_irq_reg, err_irq_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;

  // Syndrome and classification of the word on the read return path
  logic [SSEU_CHK_W-1:0] syn;
  logic [SSEU_CHK_W-1:0] gen_chk;
  logic err_single;
  logic err_double;
  logic chk_now;
  logic log_take;
  logic apb_wr;
  logic st_clr_hit;
  logic [SSEU_DATA_W-1:0] fix_data;
  logic [SSEU_DATA_W-1:0] merged;
  logic [ADDR_W-1:0] beat_step;

  assign beat_step = ADDR_W'(SSEU_BEAT_BYTES);
  assign gen_chk = sseu_ecc_gen(mem_rdata[SSEU_DATA_W-1:0]);
  assign syn = {^mem_rdata, gen_chk[6:0] ^ mem_rdata[70:64]};
  // A single-error syndrome that points past the last codeword bit is treated as double
  assign err_single = syn[7] && (syn[6:0] <= 7'(SSEU_LAST_POS));
  assign err_double = (syn[6:0] != 7'h00) && !err_single;
  assign chk_now = (st_reg == S_RD_WAIT) && mem_rvalid;

  for (genvar gi = 0; gi < SSEU_DATA_W; gi++)
  begin : g_fix
    assign fix_data[gi] = mem_rdata[gi] ^ (err_single && (syn[6:0] == sseu_pos(gi)));
    assign merged[gi] = be_reg[gi/8] ? cpu_wdata[gi] : fix_data[gi];
  end

  // Transfer sequencer
  always_comb
  begin
    st_next = st_reg;
    op_next = op_reg;
    beat_next = beat_reg;
    addr_next = addr_reg;
    be_next = be_reg;
    mem_cmd_valid_next = mem_cmd_valid_reg;
    mem_cmd_write_next = mem_cmd_write_reg;
    mem_wdata_next = mem_wdata_reg;
    cpu_rdata_next = cpu_rdata_reg;
    cpu_beat_next = 1'b0;
    cpu_done_next = 1'b0;
    scrub_done_next = 1'b0;
    case (st_reg)
      S_IDLE:
      begin
        // ROM and Flash requests are not ours; the guard on done keeps a held request from being retaken
        if (cpu_req_valid && cpu_req_sdram && !cpu_done_reg)
        begin
          addr_next = cpu_req_addr;
          be_next = cpu_req_be;
          beat_next = 2'd0;
          mem_cmd_valid_next = 1'b1;
          if (cpu_req_write && cpu_req_burst)
          begin
            op_next = OP_BURST_WR;
            mem_cmd_write_next = 1'b1;
            mem_wdata_next = {sseu_ecc_gen(cpu_wdata), cpu_wdata};
            st_next = S_WR_CMD;
          end
          else
          begin
            op_next = cpu_req_write ? OP_RMW : OP_READ;
            mem_cmd_write_next = 1'b0;
            st_next = S_RD_CMD;
          end
        end
        else if (scrub_req && !scrub_done_reg)
        begin
          op_next = OP_SCRUB;
          addr_next = scrub_addr;
          mem_cmd_valid_next = 1'b1;
          mem_cmd_write_next = 1'b0;
          st_next = S_RD_CMD;
        end
      end
      S_RD_CMD:
      begin
        if (mem_cmd_ready)
        begin
          mem_cmd_valid_next = 1'b0;
          st_next = S_RD_WAIT;
        end
      end
      S_RD_WAIT:
      begin
        if (mem_rvalid)
        begin
          case (op_reg)
            OP_READ:
            begin
              // Double errors hand back the raw word; the cycle still ends normally
              cpu_rdata_next = err_double ? mem_rdata[SSEU_DATA_W-1:0] : fix_data;
              cpu_beat_next = 1'b1;
              if (!cpu_req_burst || beat_reg == 2'(SSEU_BURST_BEATS - 1))
              begin
                cpu_done_next = 1'b1;
                st_next = S_IDLE;
              end
              else
              begin
                beat_next = beat_reg + 2'd1;
                addr_next = addr_reg + beat_step;
                mem_cmd_valid_next = 1'b1;
                st_next = S_RD_CMD;
              end
            end
            OP_RMW:
            begin
              if (err_double)
              begin
                cpu_done_next = 1'b1;
                st_next = S_IDLE;
              end
              else
              begin
                mem_cmd_valid_next = 1'b1;
                mem_cmd_write_next = 1'b1;
                mem_wdata_next = {sseu_ecc_gen(merged), merged};
                st_next = S_WR_CMD;
              end
            end
            default:
            begin
              if (err_single && ctrl_reg[SSEU_CTRL_SCRUB_WB_EN])
              begin
                mem_cmd_valid_next = 1'b1;
                mem_cmd_write_next = 1'b1;
                mem_wdata_next = {sseu_ecc_gen(fix_data), fix_data};
                st_next = S_WR_CMD;
              end
              else
              begin
                scrub_done_next = 1'b1;
                st_next = S_IDLE;
              end
            end
          endcase
        end
      end
      S_WR_CMD:
      begin
        if (mem_cmd_ready)
        begin
          mem_cmd_valid_next = 1'b0;
          mem_cmd_write_next = 1'b0;
          if (op_reg == OP_BURST_WR)
          begin
            cpu_beat_next = 1'b1;
            if (beat_reg == 2'(SSEU_BURST_BEATS - 1))
            begin
              cpu_done_next = 1'b1;
              st_next = S_IDLE;
            end
            else
            begin
              beat_next = beat_reg + 2'd1;
              addr_next = addr_reg + beat_step;
              st_next = S_WR_GAP;
            end
          end
          else if (op_reg == OP_SCRUB)
          begin
            scrub_done_next = 1'b1;
            st_next = S_IDLE;
          end
          else
          begin
            cpu_done_next = 1'b1;
            st_next = S_IDLE;
          end
        end
      end
      // The master moves to the next beat's data only after it sees the beat pulse
      S_WR_GAP:
      begin
        st_next = S_WR_LOAD;
      end
      S_WR_LOAD:
      begin
        mem_cmd_valid_next = 1'b1;
        mem_cmd_write_next = 1'b1;
        mem_wdata_next = {sseu_ecc_gen(cpu_wdata), cpu_wdata};
        st_next = S_WR_CMD;
      end
      default:
      begin
        st_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= S_IDLE;
      op_reg <= OP_READ;
      beat_reg <= 2'd0;
      addr_reg <= '0;
      be_reg <= '0;
      mem_cmd_valid_reg <= 1'b0;
      mem_cmd_write_reg <= 1'b0;
      mem_wdata_reg <= '0;
      cpu_rdata_reg <= '0;
      cpu_beat_reg <= 1'b0;
      cpu_done_reg <= 1'b0;
      scrub_done_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      op_reg <= op_next;
      beat_reg <= beat_next;
      addr_reg <= addr_next;
      be_reg <= be_next;
      mem_cmd_valid_reg <= mem_cmd_valid_next;
      mem_cmd_write_reg <= mem_cmd_write_next;
      mem_wdata_reg <= mem_wdata_next;
      cpu_rdata_reg <= cpu_rdata_next;
      cpu_beat_reg <= cpu_beat_next;
      cpu_done_reg <= cpu_done_next;
      scrub_done_reg <= scrub_done_next;
    end
  end

  // Error log, event flags and APB registers
  assign apb_wr = psel && penable && pready_reg && pwrite;
  assign st_clr_hit = apb_wr && (paddr == SSEU_OFS_STATUS);
  assign log_take = chk_now && (err_single || err_double)
                    && (op_reg != OP_SCRUB || ctrl_reg[SSEU_CTRL_SCRUB_LOG_EN])
                    && (!elog_reg || (st_clr_hit && pwdata[SSEU_ST_ELOG]) || (!elog_mbe_reg && err_double));

  always_comb
  begin
    ctrl_next = ctrl_reg;
    sbe_ev_next = sbe_ev_reg;
    mbe_ev_next = mbe_ev_reg;
    ovf_next = ovf_reg;
    elog_next = elog_reg;
    elog_mbe_next = elog_mbe_reg;
    elog_addr_next = elog_addr_reg;
    elog_synd_next = elog_synd_reg;
    sbe_cnt_next = sbe_cnt_reg;
    mchk_n_next = mchk_n_reg;
    prdata_next = prdata_reg;
    pready_next = psel && !penable;
    pslverr_next = 1'b0;
    if (apb_wr && paddr == SSEU_OFS_CTRL)
      ctrl_next = pwdata[SSEU_CTRL_W-1:0];
    if (apb_wr && paddr == SSEU_OFS_SBE_COUNT)
      sbe_cnt_next = pwdata[SSEU_SBE_CNT_W-1:0];
    // Write-one-to-clear; a hardware set in the same cycle is applied afterwards and wins
    if (st_clr_hit)
    begin
      if (pwdata[SSEU_ST_SBE])
        sbe_ev_next = 1'b0;
      if (pwdata[SSEU_ST_MBE])
        mbe_ev_next = 1'b0;
      if (pwdata[SSEU_ST_OVF])
        ovf_next = 1'b0;
      if (pwdata[SSEU_ST_ELOG])
      begin
        elog_next = 1'b0;
        elog_mbe_next = 1'b0;
      end
      if (pwdata[SSEU_ST_MCHK])
        mchk_n_next = 1'b1;
    end
    if (chk_now && err_single)
    begin
      sbe_ev_next = 1'b1;
      sbe_cnt_next = sbe_cnt_reg + SSEU_SBE_CNT_W'(1);
      if (sbe_cnt_reg == {SSEU_SBE_CNT_W{1'b1}})
        ovf_next = 1'b1;
    end
    if (chk_now && err_double)
    begin
      mbe_ev_next = 1'b1;
      if (op_reg != OP_SCRUB && ctrl_reg[SSEU_CTRL_MCHK_EN])
        mchk_n_next = 1'b0;
    end
    if (log_take)
    begin
      elog_next = 1'b1;
      elog_mbe_next = err_double;
      elog_addr_next = addr_reg;
      elog_synd_next = syn;
    end
    if (psel && !penable)
    begin
      case (paddr)
        SSEU_OFS_CTRL: prdata_next = 32'(ctrl_reg);
        SSEU_OFS_STATUS: prdata_next = 32'({!mchk_n_reg, elog_mbe_reg, elog_reg, ovf_reg, mbe_ev_reg, sbe_ev_reg});
        SSEU_OFS_ELOG_ADDR: prdata_next = 32'(elog_addr_reg);
        SSEU_OFS_ELOG_SYND: prdata_next = 32'(elog_synd_reg);
        SSEU_OFS_SBE_COUNT: prdata_next = 32'(sbe_cnt_reg);
        default:
        begin
          prdata_next = 32'h00000000;
          pslverr_next = 1'b1;
        end
      endcase
    end
    // Interrupt follows the sticky flags by one cycle
    err_irq_next = (sbe_ev_reg && ctrl_reg[SSEU_CTRL_SBE_IRQ_EN])
                   || (mbe_ev_reg && ctrl_reg[SSEU_CTRL_MBE_IRQ_EN])
                   || (ovf_reg && ctrl_reg[SSEU_CTRL_OVF_IRQ_EN]);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= SSEU_CTRL_RESET;
      sbe_ev_reg <= 1'b0;
      mbe_ev_reg <= 1'b0;
      ovf_reg <= 1'b0;
      elog_reg <= 1'b0;
      elog_mbe_reg <= 1'b0;
      elog_addr_reg <= '0;
      elog_synd_reg <= '0;
      sbe_cnt_reg <= '0;
      mchk_n_reg <= 1'b1;
      err_irq_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      sbe_ev_reg <= sbe_ev_next;
      mbe_ev_reg <= mbe_ev_next;
      ovf_reg <= ovf_next;
      elog_reg <= elog_next;
      elog_mbe_reg <= elog_mbe_next;
      elog_addr_reg <= elog_addr_next;
      elog_synd_reg <= elog_synd_next;
      sbe_cnt_reg <= sbe_cnt_next;
      mchk_n_reg <= mchk_n_next;
      err_irq_reg <= err_irq_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign cpu_rdata = cpu_rdata_reg;
  assign cpu_beat = cpu_beat_reg;
  assign cpu_done = cpu_done_reg;
  assign scrub_done = scrub_done_reg;
  assign mem_cmd_valid = mem_cmd_valid_reg;
  assign mem_cmd_write = mem_cmd_write_reg;
  assign mem_addr = addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign err_irq = err_irq_reg;
  assign machine_check_out_n = mchk_n_reg;

  a_full_word_chk: assert property (@(posedge pclk) disable iff (!presetn)
    mem_cmd_valid_reg && mem_cmd_write_reg |-> mem_wdata_reg[71:64] == sseu_ecc_gen(mem_wdata_reg[63:0]))
    else $error("write word carries wrong check bits");
  a_mchk_on_double: assert property (@(posedge pclk) disable iff (!presetn)
    chk_now && err_double && op_reg != OP_SCRUB && ctrl_reg[SSEU_CTRL_MCHK_EN] |=> !machine_check_out_n ##1 !machine_check_out_n || st_clr_hit)
    else $error("machine check not raised on double error");
  a_read_single_fix: assert property (@(posedge pclk) disable iff (!presetn)
    chk_now && err_single && op_reg == OP_READ |=> cpu_beat && sbe_ev_reg
      && sseu_ecc_gen(cpu_rdata) == sseu_ecc_gen($past(fix_data)))
    else $error("single error read not corrected");
  a_rmw_double_drop: assert property (@(posedge pclk) disable iff (!presetn)
    chk_now && err_double && op_reg == OP_RMW |=> cpu_done && !mem_cmd_valid ##1 !mem_cmd_write)
    else $error("write-back issued after double error");
  a_scrub_double_skip: assert property (@(posedge pclk) disable iff (!presetn)
    chk_now && err_double && op_reg == OP_SCRUB |=> scrub_done && !mem_cmd_valid)
    else $error("scrub wrote back after double error");
  a_scrub_quiet_bus: assert property (@(posedge pclk) disable iff (!presetn)
    op_reg == OP_SCRUB && st_reg != S_IDLE |=> !cpu_beat && !cpu_done)
    else $error("scrub visible on processor side");
  a_burst_no_report: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg == S_WR_LOAD || st_reg == S_WR_GAP |=> !$rose(sbe_ev_reg) && !$rose(mbe_ev_reg))
    else $error("error reported during burst write");
  a_log_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    elog_reg && elog_mbe_reg && !st_clr_hit |=> $stable(elog_addr_reg) && $stable(elog_synd_reg))
    else $error("logged double error overwritten");
  a_scrub_log_gate: assert property (@(posedge pclk) disable iff (!presetn)
    chk_now && op_reg == OP_SCRUB && !ctrl_reg[SSEU_CTRL_SCRUB_LOG_EN] && !elog_reg |=> !elog_reg)
    else $error("scrub error logged while disabled");
  a_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !sbe_ev_reg && !mbe_ev_reg && !ovf_reg |=> !err_irq)
    else $error("interrupt without enabled source");
  a_rom_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg == S_IDLE && cpu_req_valid && !cpu_req_sdram && !scrub_req |=> st_reg == S_IDLE && !mem_cmd_valid)
    else $error("ROM request reached SDRAM");

endmodule : sseu_top

// >>> verification/sseu_mem_model.sv
// SDRAM array model: eight-word store, stalling command port, delayed reads
`timescale 1ns/1ns
module sseu_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic mem_cmd_valid,
  output logic mem_cmd_ready,
  input wire logic mem_cmd_write,
  input wire logic [31:0] mem_addr,
  input wire logic [71:0] mem_wdata,
  output logic mem_rvalid,
  output logic [71:0] mem_rdata,
  output int wr_count
);
  logic [71:0] mem [8];
  logic [2:0] idx;
  logic pend, ph;
  // Slow mode holds ready low every other cycle and stretches reads
  assign mem_cmd_ready = !pend && (!slow || ph);
  // Whole 72-bit words only; no error-acknowledge path exists here
  always @(posedge pclk)
    if (mem_cmd_valid && mem_cmd_ready && mem_cmd_write)
      mem[mem_addr[5:3]] <= mem_wdata;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pend <= 1'b0;
      ph <= 1'b0;
      mem_rvalid <= 1'b0;
      mem_rdata <= 72'h0;
      wr_count <= 0;
    end
    else
    begin
      ph <= ~ph;
      if (mem_cmd_valid && mem_cmd_ready && mem_cmd_write)
        wr_count <= wr_count + 1;
      mem_rvalid <= pend && (!slow || ph);
      // Idle bus toggles so a stale word can never pass for fresh data
      mem_rdata <= (pend && (!slow || ph)) ? mem[idx] : ~mem_rdata;
      if (mem_cmd_valid && mem_cmd_ready && !mem_cmd_write)
      begin
        pend <= 1'b1;
        idx <= mem_addr[5:3];
      end
      else if (!slow || ph)
        pend <= 1'b0;
    end
endmodule : sseu_mem_model

// >>> verification/sseu_top_tb_top.sv
// Testbench: APB and processor master, SDRAM model and result scoreboard
`timescale 1ns/1ns
module sseu_top_tb_top;
  import sseu_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, slow = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, cpu_req_addr = 0, scrub_addr = 0, mem_addr;
  logic cpu_req_valid = 0, cpu_req_sdram = 1, cpu_req_write = 0, cpu_req_burst = 0, cpu_beat, cpu_done;
  logic scrub_req = 0, scrub_done, mem_cmd_valid, mem_cmd_ready, mem_cmd_write, mem_rvalid;
  logic err_irq, machine_check_out_n;
  logic [7:0] cpu_req_be = 0;
  logic [63:0] cpu_wdata = 0, cpu_rdata, lfsr = 64'h18, d[4];
  logic [71:0] mem_wdata, mem_rdata, q[$];
  int n_errors = 0, check_count = 0, wr_count, w0;
  sseu_top i_sseu_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cpu_req_valid, .cpu_req_sdram, .cpu_req_write, .cpu_req_burst, .cpu_req_addr, .cpu_req_be, .cpu_wdata,
    .cpu_rdata, .cpu_beat, .cpu_done, .scrub_req, .scrub_addr, .scrub_done, .mem_cmd_valid, .mem_cmd_ready,
    .mem_cmd_write, .mem_addr, .mem_wdata, .mem_rvalid, .mem_rdata, .err_irq, .machine_check_out_n);
  sseu_mem_model i_sseu_mem_model (.pclk, .presetn, .slow, .mem_cmd_valid, .mem_cmd_ready, .mem_cmd_write,
    .mem_addr, .mem_wdata, .mem_rvalid, .mem_rdata, .wr_count);
  always #4 pclk = ~pclk;
  task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  function automatic logic [63:0] rnd();
    lfsr = {lfsr[62:0], lfsr[63] ^ lfsr[62] ^ lfsr[60] ^ lfsr[59]};
    return lfsr;
  endfunction : rnd
  // Scoreboard: any beat seen during a scrub finds the queue empty
  always @(posedge pclk)
    if ((psel && penable && pready && !pwrite) || (cpu_beat && !cpu_req_write))
    begin
      if (q.size() == 0)
        chk(72'h1, 72'h0);
      else
        chk(cpu_beat ? {8'h00, cpu_rdata} : {39'h0, pslverr, prdata}, q.pop_front());
    end
  task automatic apb(input logic w, input logic [11:0] a, input logic [32:0] v);
    if (!w)
      q.push_back({39'h0, v});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v[31:0];
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic run(input logic s, input logic w, input logic b, input logic [31:0] a, input logic [7:0] be);
    int t;
    int k;
    t = 0;
    k = 0;
    @(posedge pclk);
    scrub_req <= s;
    scrub_addr <= a;
    cpu_req_valid <= !s;
    cpu_req_write <= w;
    cpu_req_burst <= b;
    cpu_req_addr <= a;
    cpu_req_be <= be;
    cpu_wdata <= d[0];
    do
    begin
      @(posedge pclk);
      t++;
      if (cpu_beat === 1'b1 && w && k < 3)
      begin
        k++;
        cpu_wdata <= d[k];
      end
    end
    while ((s ? scrub_done : cpu_done) !== 1'b1 && t < 300);
    if (t >= 300)
      chk(72'h1, 72'h0);
    scrub_req <= 1'b0;
    cpu_req_valid <= 1'b0;
  endtask : run
  initial
  begin
    #200000;
    chk(72'h1, 72'h0);
    give_verdict();
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, SSEU_OFS_CTRL, 33'h0);
    apb(1'b0, 12'h020, 33'h100000000);
    cpu_req_sdram <= 1'b0;
    cpu_req_valid <= 1'b1;
    repeat (20)
    begin
      @(posedge pclk);
      chk({mem_cmd_valid, cpu_done}, 72'h0);
    end
    cpu_req_valid <= 1'b0;
    cpu_req_sdram <= 1'b1;
    $display("rom test done");
    apb(1'b1, SSEU_OFS_CTRL, 33'h2F);
    foreach (d[i])
      d[i] = rnd();
    run(1'b0, 1'b1, 1'b1, 32'h40, 8'hFF);
    chk(wr_count, 72'h4);
    for (int i = 0; i < 4; i++)
      chk(i_sseu_mem_model.mem[i][63:0], d[i]);
    apb(1'b0, SSEU_OFS_STATUS, 33'h0);
    i_sseu_mem_model.mem[1][5] <= ~i_sseu_mem_model.mem[1][5];
    slow <= 1'b1;
    foreach (d[i])
      q.push_back({8'h00, d[i]});
    run(1'b0, 1'b0, 1'b1, 32'h40, 8'hFF);
    chk(err_irq, 72'h1);
    apb(1'b0, SSEU_OFS_STATUS, 33'h09);
    apb(1'b0, SSEU_OFS_ELOG_ADDR, 33'h48);
    $display("burst test done");
    i_sseu_mem_model.mem[2][1:0] <= ~i_sseu_mem_model.mem[2][1:0];
    q.push_back({8'h00, d[2] ^ 64'h3});
    run(1'b0, 1'b0, 1'b0, 32'h50, 8'hFF);
    q.push_back({8'h00, d[1]});
    run(1'b0, 1'b0, 1'b0, 32'h48, 8'hFF);
    apb(1'b0, SSEU_OFS_ELOG_ADDR, 33'h50);
    apb(1'b0, SSEU_OFS_STATUS, 33'h3B);
    chk(machine_check_out_n, 72'h0);
    apb(1'b1, SSEU_OFS_STATUS, 33'h3F);
    apb(1'b0, SSEU_OFS_STATUS, 33'h0);
    chk({err_irq, machine_check_out_n}, 72'h1);
    $display("read error test done");
    d[0] = rnd();
    i_sseu_mem_model.mem[3][70] <= ~i_sseu_mem_model.mem[3][70];
    run(1'b0, 1'b1, 1'b0, 32'h58, 8'h0F);
    d[3] = {d[3][63:32], d[0][31:0]};
    chk(i_sseu_mem_model.mem[3][63:0], d[3]);
    q.push_back({8'h00, d[3]});
    run(1'b0, 1'b0, 1'b0, 32'h58, 8'hFF);
    apb(1'b0, SSEU_OFS_STATUS, 33'h09);
    i_sseu_mem_model.mem[0][3:2] <= ~i_sseu_mem_model.mem[0][3:2];
    w0 = wr_count;
    run(1'b0, 1'b1, 1'b0, 32'h40, 8'hFF);
    apb(1'b0, SSEU_OFS_STATUS, 33'h3B);
    apb(1'b0, SSEU_OFS_ELOG_ADDR, 33'h40);
    chk(wr_count - w0, 72'h0);
    apb(1'b1, SSEU_OFS_STATUS, 33'h3F);
    $display("rmw test done");
    run(1'b1, 1'b0, 1'b0, 32'h48, 8'h00);
    apb(1'b0, SSEU_OFS_STATUS, 33'h01);
    chk(i_sseu_mem_model.mem[1][63:0], d[1]);
    w0 = wr_count;
    run(1'b1, 1'b0, 1'b0, 32'h40, 8'h00);
    chk(wr_count - w0, 72'h0);
    apb(1'b0, SSEU_OFS_STATUS, 33'h03);
    chk({err_irq, machine_check_out_n}, 72'h3);
    apb(1'b1, SSEU_OFS_CTRL, 33'h3F);
    apb(1'b1, SSEU_OFS_STATUS, 33'h3F);
    run(1'b1, 1'b0, 1'b0, 32'h40, 8'h00);
    apb(1'b0, SSEU_OFS_STATUS, 33'h1A);
    // Data bits 2 and 3 sit at codeword positions 6 and 7, so the syndrome is 1 with even parity
    apb(1'b0, SSEU_OFS_ELOG_SYND, 33'h01);
    apb(1'b0, SSEU_OFS_SBE_COUNT, 33'h04);
    $display("scrub test done");
    give_verdict();
  end
endmodule : sseu_top_tb_top
